// >>> logic/efr_pkg.sv
// Function
// - One extension component per set capability bit, each of fixed size
// - Zero capability word means no extension area at all
// - Area size is highest set select bit plus that component's size
// - Select bit 0 highest: area 16 bytes long, 16 below register area
// - Component i is stored only when select bit i is one
// - Fault record sits next to register area, later ones descend below it
// - Record written for protection and page faults when both bits 0 set
// - Offset 0 holds page fault address, cleared for protection faults
// - Offset 8 holds the 4-byte error code, then 4 reserved bytes
// - Page fault code bits 0,1,3,4 copy the ordinary page fault flags
// - Page fault code bit 2 always reads one
// - Page faults with user flag zero are never recorded
// - Bit 5 marks protection key fault, bit 15 cache map fault
// - Descriptor read as four 8-byte fields at 0, 8, 16 and 24
// - Security descriptor: 8-byte flags then 56 zero bytes
// - Flag bits 0,1,2 grant read, write, execute; zero denies
// - Flag bit 3 means pending, flag bit 4 means modified
// - Flag bit 5 means permission restriction in progress
// - Flag bits 15:8 give page kind; 7:6 and 63:16 are zero
// - Page kinds 0 to 4 are defined, others reserved
// - Vectors 14 and 13 reported only when select bit 0 set
package efr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CAP = 8'h00;
    localparam logic [7:0] OFS_SELECT = 8'h04;
    localparam logic [7:0] OFS_AREA_SIZE = 8'h08;
    localparam logic [7:0] OFS_AREA_POS = 8'h0C;
    localparam logic [7:0] OFS_REC_ADDR_LO = 8'h10;
    localparam logic [7:0] OFS_REC_ADDR_HI = 8'h14;
    localparam logic [7:0] OFS_REC_CODE = 8'h18;
    localparam logic [7:0] OFS_REC_RSVD = 8'h1C;
    localparam logic [7:0] OFS_EXIT = 8'h20;
    localparam logic [7:0] OFS_DESC_ADDR = 8'h24;
    localparam logic [7:0] OFS_DESC_STAT = 8'h28;
    localparam logic [7:0] OFS_LIN_LO = 8'h2C;
    localparam logic [7:0] OFS_SRC_LO = 8'h30;
    localparam logic [7:0] OFS_META_LO = 8'h34;
    localparam logic [7:0] OFS_CTL_LO = 8'h38;
    localparam logic [7:0] OFS_FLAGS = 8'h3C;
    // Reset values
    localparam logic [31:0] RST_SELECT = 32'h0000_0000;
    localparam logic [31:0] CAP_DEFAULT = 32'h0000_0001;
    // Frame geometry in bytes
    localparam logic [15:0] GPR_AREA_OFS = 16'h0F48;
    localparam logic [15:0] FAULT_REC_SIZE = 16'h0010;
    localparam logic [15:0] FUTURE_COMP_SIZE = 16'h0000;
    // Fault vectors
    localparam logic [7:0] VEC_GP = 8'h0D;
    localparam logic [7:0] VEC_PF = 8'h0E;
    // Error code bit positions
    localparam int EC_PRESENT = 0;
    localparam int EC_WRITE = 1;
    localparam int EC_USER = 2;
    localparam int EC_RSVD_BIT = 3;
    localparam int EC_IFETCH = 4;
    localparam int EC_PROT_KEY = 5;
    localparam int EC_CACHE_MAP = 15;
    // Security flag bit positions
    localparam int FL_READ = 0;
    localparam int FL_WRITE = 1;
    localparam int FL_EXEC = 2;
    localparam int FL_PENDING = 3;
    localparam int FL_MODIFIED = 4;
    localparam int FL_RESTRICT = 5;
    localparam int FL_KIND_LSB = 8;
    localparam logic [7:0] KIND_MAX = 8'h04;
    // Descriptor fetch: 4 operation words, 1 flag word, 7 zero words
    localparam logic [2:0] PGOP_WORDS = 3'h3;
    localparam logic [2:0] SECR_WORDS = 3'h6;
    localparam logic [4:0] DESC_ALIGN_MASK = 5'h1F;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0008;
    // Descriptor fetch states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PGOP = 4'b0010,
        ST_SECF = 4'b0100,
        ST_SECR = 4'b1000
    } efr_state_e;
endpackage

// >>> logic/efr_area_calc.sv
// Works out extension area geometry from capability and select words
module efr_area_calc
    import efr_pkg::*;
(
    input wire logic [31:0] i_cap,
    input wire logic [31:0] i_sel,
    output logic o_rec_en,
    output logic [15:0] o_size,
    output logic [15:0] o_pos
);
    logic [4:0] top_bit;
    logic any_sel;
    logic [15:0] comp_size;

    // Highest select bit among supported components
    always_comb begin
        top_bit = 5'h00;
        any_sel = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (i_sel[i] && i_cap[i]) begin
                top_bit = 5'(i);
                any_sel = 1'b1;
            end
        end
    end

    // Only component 0 has a defined size today
    assign comp_size = (top_bit == 5'h00) ? FAULT_REC_SIZE
                                          : FUTURE_COMP_SIZE;

    // Size is highest bit plus its component size; none without capability
    always_comb begin
        if (i_cap == 32'h0000_0000 || !any_sel) begin
            o_size = 16'h0000;
        end else begin
            o_size = 16'(top_bit) + comp_size;
        end
    end

    // Area grows downward from just below the register save area
    assign o_pos = GPR_AREA_OFS - o_size;
    assign o_rec_en = i_cap[0] & i_sel[0];
endmodule

// >>> logic/efr_core.sv
// Chosen here: the APB slave port and the register offsets.
module efr_core
    import efr_pkg::*;
#(
    parameter logic [31:0] CAP_WORD = efr_pkg::CAP_DEFAULT
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    input wire logic I_FLT_VALID,
    input wire logic [7:0] I_FLT_VEC,
    input wire logic [63:0] I_FLT_ADDR,
    input wire logic [31:0] I_FLT_CODE,
    input wire logic I_FLT_PROT_KEY,
    input wire logic I_FLT_CACHE_MAP,
    output logic O_REC_WRITE,
    output logic O_MEM_REQ,
    output logic [31:0] O_MEM_ADDR,
    input wire logic I_MEM_VALID,
    input wire logic [63:0] I_MEM_DATA,
    input wire logic I_ACC_RD,
    input wire logic I_ACC_WR,
    input wire logic I_ACC_EX,
    output logic O_ACC_DENY,
    output logic O_PENDING,
    output logic O_MODIFIED,
    output logic O_RESTRICT_ACTIVE,
    output logic [7:0] O_PAGE_KIND
);
    import efr_pkg::*;

    typedef struct packed {
        logic [31:0] sel;
        logic [63:0] rec_addr;
        logic [31:0] rec_code;
        logic [7:0] exit_vec;
        logic exit_ok;
        logic rec_write;
        efr_state_e st;
        logic [2:0] cnt;
        logic [31:0] mem_addr;
        logic mem_req;
        logic [63:0] lin;
        logic [63:0] src;
        logic [63:0] meta;
        logic [63:0] ctl;
        logic [63:0] flags;
        logic align_err;
        logic rsvd_err;
        logic deny;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } efr_core_s;

    efr_core_s q, d;
    logic rec_en;
    logic [15:0] area_size;
    logic [15:0] area_pos;
    logic acc, wr_take;
    logic is_pf, is_gp, user_ok;
    logic [31:0] rd_mux;
    logic rd_hit;

    efr_area_calc u_area (
        .i_cap(CAP_WORD),
        .i_sel(q.sel),
        .o_rec_en(rec_en),
        .o_size(area_size),
        .o_pos(area_pos)
    );

    // Bus phase decode; writes land on the edge that sees pready high
    assign acc = I_PSEL & I_PENABLE;
    assign wr_take = acc & q.pready & I_PWRITE;
    assign is_pf = I_FLT_VEC == VEC_PF;
    assign is_gp = I_FLT_VEC == VEC_GP;
    assign user_ok = !is_pf || I_FLT_CODE[EC_USER];

    // Read multiplexer and unmapped address detection
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (I_PADDR == OFS_CAP) begin
            rd_mux = CAP_WORD;
        end else if (I_PADDR == OFS_SELECT) begin
            rd_mux = q.sel;
        end else if (I_PADDR == OFS_AREA_SIZE) begin
            rd_mux = {16'h0000, area_size};
        end else if (I_PADDR == OFS_AREA_POS) begin
            rd_mux = {16'h0000, area_pos};
        end else if (I_PADDR == OFS_REC_ADDR_LO) begin
            rd_mux = q.rec_addr[31:0];
        end else if (I_PADDR == OFS_REC_ADDR_HI) begin
            rd_mux = q.rec_addr[63:32];
        end else if (I_PADDR == OFS_REC_CODE) begin
            rd_mux = q.rec_code;
        end else if (I_PADDR == OFS_REC_RSVD) begin
            rd_mux = 32'h0000_0000;
        end else if (I_PADDR == OFS_EXIT) begin
            rd_mux = {q.exit_ok, 23'h000000, q.exit_vec};
        end else if (I_PADDR == OFS_DESC_ADDR) begin
            rd_mux = q.mem_addr;
        end else if (I_PADDR == OFS_DESC_STAT) begin
            rd_mux = {29'h0, q.st != ST_IDLE, q.rsvd_err, q.align_err};
        end else if (I_PADDR == OFS_LIN_LO) begin
            rd_mux = q.lin[31:0];
        end else if (I_PADDR == OFS_SRC_LO) begin
            rd_mux = q.src[31:0];
        end else if (I_PADDR == OFS_META_LO) begin
            rd_mux = q.meta[31:0];
        end else if (I_PADDR == OFS_CTL_LO) begin
            rd_mux = q.ctl[31:0];
        end else if (I_PADDR == OFS_FLAGS) begin
            rd_mux = q.flags[31:0];
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Next state of the whole block
    always_comb begin
        d = q;
        d.rec_write = 1'b0;
        // Bus slave: one wait cycle, then answer with registered data
        d.pready = acc & !q.pready;
        if (acc && !q.pready) begin
            d.prdata = I_PWRITE ? 32'h0000_0000 : rd_mux;
            d.pslverr = !rd_hit;
        end
        if (wr_take && I_PADDR == OFS_SELECT) begin
            d.sel = I_PWDATA & CAP_WORD;
        end
        // Fault capture into the detail record
        if (I_FLT_VALID) begin
            d.exit_ok = 1'b0;
            d.exit_vec = 8'h00;
            if ((is_pf || is_gp) && rec_en && user_ok) begin
                d.exit_ok = 1'b1;
                d.exit_vec = I_FLT_VEC;
                d.rec_write = 1'b1;
                d.rec_addr = is_pf ? I_FLT_ADDR : 64'h0;
                d.rec_code = 32'h0000_0000;
                if (is_pf) begin
                    d.rec_code[EC_PRESENT] = I_FLT_CODE[EC_PRESENT];
                    d.rec_code[EC_WRITE] = I_FLT_CODE[EC_WRITE];
                    d.rec_code[EC_USER] = 1'b1;
                    d.rec_code[EC_RSVD_BIT] = I_FLT_CODE[EC_RSVD_BIT];
                    d.rec_code[EC_IFETCH] = I_FLT_CODE[EC_IFETCH];
                    d.rec_code[EC_PROT_KEY] = I_FLT_PROT_KEY;
                    d.rec_code[EC_CACHE_MAP] = I_FLT_CACHE_MAP;
                end else begin
                    d.rec_code = I_FLT_CODE;
                end
            end
        end
        // Access check against the decoded permissions
        d.deny = (I_ACC_RD & !q.flags[FL_READ])
               | (I_ACC_WR & !q.flags[FL_WRITE])
               | (I_ACC_EX & !q.flags[FL_EXEC]);
        // Descriptor fetch sequencer
        case (q.st)
            ST_IDLE: begin
                if (wr_take && I_PADDR == OFS_DESC_ADDR) begin
                    d.mem_addr = I_PWDATA;
                    d.rsvd_err = 1'b0;
                    d.align_err = |(I_PWDATA[4:0] & DESC_ALIGN_MASK);
                    if (!d.align_err) begin
                        d.st = ST_PGOP;
                        d.cnt = 3'h0;
                        d.mem_req = 1'b1;
                    end
                end
            end
            ST_PGOP: begin
                if (I_MEM_VALID) begin
                    case (q.cnt)
                        3'h0: d.lin = I_MEM_DATA;
                        3'h1: d.src = I_MEM_DATA;
                        3'h2: d.meta = I_MEM_DATA;
                        default: d.ctl = I_MEM_DATA;
                    endcase
                    d.cnt = q.cnt + 3'h1;
                    d.mem_addr = q.mem_addr + WORD_BYTES;
                    if (q.cnt == PGOP_WORDS) begin
                        d.st = ST_SECF;
                        d.mem_addr = q.meta[31:0];
                    end
                end
            end
            ST_SECF: begin
                if (I_MEM_VALID) begin
                    d.flags = I_MEM_DATA;
                    if (I_MEM_DATA[7:6] != 2'h0
                        || I_MEM_DATA[63:16] != 48'h0
                        || I_MEM_DATA[15:8] > KIND_MAX) begin
                        d.rsvd_err = 1'b1;
                    end
                    d.st = ST_SECR;
                    d.cnt = 3'h0;
                    d.mem_addr = q.mem_addr + WORD_BYTES;
                end
            end
            ST_SECR: begin
                if (I_MEM_VALID) begin
                    if (I_MEM_DATA != 64'h0) begin
                        d.rsvd_err = 1'b1;
                    end
                    d.cnt = q.cnt + 3'h1;
                    d.mem_addr = q.mem_addr + WORD_BYTES;
                    if (q.cnt == SECR_WORDS) begin
                        d.st = ST_IDLE;
                        d.mem_req = 1'b0;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
                d.mem_req = 1'b0;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            q <= '0;
            q.sel <= RST_SELECT;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign O_PREADY = q.pready;
    assign O_PRDATA = q.prdata;
    assign O_PSLVERR = q.pslverr;
    assign O_REC_WRITE = q.rec_write;
    assign O_MEM_REQ = q.mem_req;
    assign O_MEM_ADDR = q.mem_addr;
    assign O_ACC_DENY = q.deny;
    assign O_PENDING = q.flags[FL_PENDING];
    assign O_MODIFIED = q.flags[FL_MODIFIED];
    assign O_RESTRICT_ACTIVE = q.flags[FL_RESTRICT];
    assign O_PAGE_KIND = q.flags[15:8];

    // Checks on the block's own behaviour
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    sequence s_fault_ok;
        I_FLT_VALID && (is_pf || is_gp) && rec_en && user_ok;
    endsequence

    sequence s_pf_kernel;
        I_FLT_VALID && is_pf && !I_FLT_CODE[EC_USER];
    endsequence

    // Last of the seven trailing security words arrives
    sequence s_secr_last;
        q.st == ST_SECR && I_MEM_VALID && q.cnt == SECR_WORDS;
    endsequence

    rec_store_a: assert property (
        s_fault_ok |=> O_REC_WRITE && q.exit_ok)
        else $error("fault record not written");
    rec_gate_a: assert property (
        I_FLT_VALID && !rec_en |=> !O_REC_WRITE && !q.exit_ok)
        else $error("record written while not selected");
    user_skip_a: assert property (
        s_pf_kernel |=> !O_REC_WRITE)
        else $error("supervisor page fault recorded");
    user_bit_a: assert property (
        O_REC_WRITE && q.exit_vec == VEC_PF |-> q.rec_code[EC_USER]
            && q.rec_addr == $past(I_FLT_ADDR))
        else $error("page fault record fields wrong");
    gp_addr_a: assert property (
        O_REC_WRITE && q.exit_vec == VEC_GP |-> q.rec_addr == 64'h0)
        else $error("protection fault address not cleared");
    code_rsvd_a: assert property (
        O_REC_WRITE && q.exit_vec == VEC_PF
            |-> q.rec_code[14:6] == 9'h0 && q.rec_code[31:16] == 16'h0)
        else $error("reserved code bits set");
    align_chk_a: assert property (
        q.st == ST_IDLE && wr_take && I_PADDR == OFS_DESC_ADDR
            && I_PWDATA[4:0] != 5'h00 |=> q.align_err && !O_MEM_REQ)
        else $error("misaligned descriptor fetched");
    perm_deny_a: assert property (
        I_ACC_WR && !q.flags[FL_WRITE] |=> O_ACC_DENY)
        else $error("write access not denied");
    no_area_a: assert property (
        CAP_WORD == 32'h0 || q.sel == 32'h0 |-> area_size == 16'h0)
        else $error("area sized without capability");
    apb_wait_a: assert property (
        acc && !O_PREADY |=> O_PREADY ##1 !O_PREADY)
        else $error("bus answer timing wrong");
    bad_addr_a: assert property (
        acc && !q.pready && !rd_hit |=> O_PSLVERR && O_PRDATA == 32'h0)
        else $error("unmapped access not refused");
    gp_code_a: assert property (
        I_FLT_VALID && is_gp && rec_en |=> q.rec_code == $past(I_FLT_CODE))
        else $error("protection fault code not stored");
    pf_copy_a: assert property (
        I_FLT_VALID && is_pf && rec_en && I_FLT_CODE[EC_USER]
            |=> ((q.rec_code ^ $past(I_FLT_CODE)) & 32'h0000_001B) == 32'h0)
        else $error("page fault flags not copied");
    fetch_go_a: assert property (
        q.st == ST_IDLE && wr_take && I_PADDR == OFS_DESC_ADDR
            && I_PWDATA[4:0] == 5'h00
            |=> O_MEM_REQ && O_MEM_ADDR == $past(I_PWDATA))
        else $error("aligned descriptor fetch not started");
    fetch_step_a: assert property (
        q.st == ST_PGOP && I_MEM_VALID && q.cnt != PGOP_WORDS
            |=> O_MEM_ADDR == $past(O_MEM_ADDR) + WORD_BYTES)
        else $error("descriptor address not stepped");
    flag_load_a: assert property (
        q.st == ST_SECF && I_MEM_VALID |=> q.flags == $past(I_MEM_DATA))
        else $error("security flags not loaded");
    kind_rsvd_a: assert property (
        q.st == ST_SECF && I_MEM_VALID && I_MEM_DATA[15:8] > KIND_MAX
            |=> q.rsvd_err)
        else $error("reserved page kind not flagged");
    fetch_end_a: assert property (
        s_secr_last |=> !O_MEM_REQ && q.st == ST_IDLE)
        else $error("fetch did not finish after last word");
endmodule

// >>> tb/efr_mem_model.sv
// Memory holding descriptors: one word per request, after dly+1 idle cycles
module efr_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [31:0] addr,
    input wire logic [31:0] dly,
    output logic valid,
    output logic [63:0] data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] mem [0:63];
    logic [63:0] last;
    int cnt;
    int served;
    // Idle bus shows the inverse of the last word, never a stale copy
    always @(posedge clk) begin
        valid <= 1'b0;
        data <= ~last;
        if (rst || !req || valid) begin
            cnt <= 0;
        end else if (cnt >= dly) begin
            valid <= 1'b1;
            data <= mem[addr[8:3]];
            last <= mem[addr[8:3]];
            served <= served + 1;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Start from a quiet bus
    initial begin
        valid = 1'b0;
        last = 64'h0;
        data = 64'h0;
        cnt = 0;
        served = 0;
    end
endmodule

// >>> tb/enclave_fault_record_and_page_meta_tb_top.sv
module enclave_fault_record_and_page_meta_tb_top import efr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    failures++; $display("MISMATCH %s expected %h seen %h", n, e, g); \
    end end
    localparam logic [31:0] CAP_W = 32'h0000_0001;
    logic clk;
    logic rst;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, flt_vec, page_kind;
    logic [31:0] pwdata, prdata, flt_code, mem_addr, rd_q;
    logic flt_valid, flt_pk, flt_cm, rec_write, err_q;
    logic [63:0] flt_addr, mem_data;
    logic mem_req, mem_valid, acc_rd, acc_wr, acc_ex, acc_deny;
    logic pending, modified, restrict_act;
    int dly;
    int failures;
    int comparisons;

    efr_core #(.CAP_WORD(CAP_W)) uut (
        .I_CLK_SYS(clk), .I_RESET(rst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
        .O_PSLVERR(pslverr), .I_FLT_VALID(flt_valid),
        .I_FLT_VEC(flt_vec), .I_FLT_ADDR(flt_addr),
        .I_FLT_CODE(flt_code), .I_FLT_PROT_KEY(flt_pk),
        .I_FLT_CACHE_MAP(flt_cm), .O_REC_WRITE(rec_write),
        .O_MEM_REQ(mem_req), .O_MEM_ADDR(mem_addr),
        .I_MEM_VALID(mem_valid), .I_MEM_DATA(mem_data),
        .I_ACC_RD(acc_rd), .I_ACC_WR(acc_wr), .I_ACC_EX(acc_ex),
        .O_ACC_DENY(acc_deny), .O_PENDING(pending),
        .O_MODIFIED(modified), .O_RESTRICT_ACTIVE(restrict_act),
        .O_PAGE_KIND(page_kind)
    );
    efr_mem_model mdl (
        .clk(clk), .rst(rst), .req(mem_req), .addr(mem_addr),
        .dly(dly), .valid(mem_valid), .data(mem_data)
    );

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One bus transfer; request held until ready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            close_out();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read data", e, rd_q)
    endtask

    // Fault pulse, then the strobe is looked at in its one cycle
    task fault(input logic [7:0] v, input logic [63:0] a,
               input logic [31:0] c, input logic pk, input logic cm,
               input logic e);
        @(posedge clk);
        flt_valid <= 1'b1;
        flt_vec <= v;
        flt_addr <= a;
        flt_code <= c;
        flt_pk <= pk;
        flt_cm <= cm;
        @(posedge clk);
        flt_valid <= 1'b0;
        #1;
        `CHK("record strobe", e, rec_write)
        @(posedge clk);
        #1;
        `CHK("strobe width", 1'b0, rec_write)
    endtask

    // Access attempt; the deny answer is registered one cycle later
    task acc(input logic r, input logic w, input logic x, input logic e);
        @(posedge clk);
        acc_rd <= r;
        acc_wr <= w;
        acc_ex <= x;
        @(posedge clk);
        #1;
        `CHK("deny", e, acc_deny)
        @(posedge clk);
        acc_rd <= 1'b0;
        acc_wr <= 1'b0;
        acc_ex <= 1'b0;
    endtask

    // Descriptor at 0x40 pointing to a security descriptor at 0x100
    task load(input logic [63:0] flags);
        mdl.mem[8] = 64'h0000_0000_7000_1000;
        mdl.mem[9] = 64'h0000_0000_0000_5000;
        mdl.mem[10] = 64'h0000_0000_0000_0100;
        mdl.mem[11] = 64'h0000_0000_0000_9000;
        mdl.mem[32] = flags;
        for (int i = 33; i < 40; i++) begin
            mdl.mem[i] = 64'h0;
        end
    endtask

    task fetch;
        int n;
        apb(1'b1, OFS_DESC_ADDR, 32'h0000_0040);
        repeat (2) @(posedge clk);
        n = 0;
        while (mem_req !== 1'b0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n >= 500) begin
            failures++;
            close_out();
        end
    endtask

    task t_reset;
        rchk(OFS_CAP, CAP_W);
        rchk(OFS_SELECT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped error", 1'b1, err_q)
        `CHK("unmapped data", 32'h0, rd_q)
    endtask

    task t_area;
        apb(1'b1, OFS_CAP, 32'h0);
        rchk(OFS_CAP, CAP_W);
        apb(1'b1, OFS_SELECT, 32'hFFFF_FFFF);
        rchk(OFS_SELECT, 32'h0000_0001);
        rchk(OFS_AREA_SIZE, 32'h0000_0010);
        rchk(OFS_AREA_POS, {16'h0, GPR_AREA_OFS - 16'h0010});
    endtask

    task t_faults;
        fault(VEC_PF, 64'h1234_5678_9ABC_D000, 32'hFFFF_FFFF,
              1, 1, 1);
        rchk(OFS_REC_ADDR_LO, 32'h9ABC_D000);
        rchk(OFS_REC_ADDR_HI, 32'h1234_5678);
        rchk(OFS_REC_CODE, 32'h0000_803F);
        rchk(OFS_REC_RSVD, 32'h0);
        rchk(OFS_EXIT, 32'h8000_000E);
        fault(VEC_PF, 64'h2000, 32'h0000_0016, 0, 0, 1);
        rchk(OFS_REC_CODE, 32'h0000_0016);
        fault(VEC_GP, 64'hDEAD_0000_BEEF_0000, 32'h0000_0018,
              0, 0, 1);
        rchk(OFS_REC_ADDR_LO, 32'h0);
        rchk(OFS_REC_ADDR_HI, 32'h0);
        rchk(OFS_REC_CODE, 32'h0000_0018);
        rchk(OFS_EXIT, 32'h8000_000D);
        fault(VEC_PF, 64'h3000, 32'h0000_0003, 0, 0, 0);
        rchk(OFS_EXIT, 32'h0);
        fault(8'h06, 64'h3000, 32'h0000_0004, 0, 0, 0);
        apb(1'b1, OFS_SELECT, 32'h0);
        fault(VEC_PF, 64'h3000, 32'h0000_0004, 0, 0, 0);
        rchk(OFS_EXIT, 32'h0);
    endtask

    task t_fetch;
        int s0;
        load(64'h0000_0000_0000_023B);
        s0 = mdl.served;
        fetch();
        `CHK("words", 12, mdl.served - s0)
        rchk(OFS_LIN_LO, 32'h7000_1000);
        rchk(OFS_SRC_LO, 32'h0000_5000);
        rchk(OFS_META_LO, 32'h0000_0100);
        rchk(OFS_CTL_LO, 32'h0000_9000);
        rchk(OFS_FLAGS, 32'h0000_023B);
        rchk(OFS_DESC_STAT, 32'h0);
        `CHK("pending", 1'b1, pending)
        `CHK("modified", 1'b1, modified)
        `CHK("restrict", 1'b1, restrict_act)
        `CHK("kind", 8'h02, page_kind)
        acc(1, 0, 0, 0);
        acc(0, 1, 0, 0);
        acc(0, 0, 1, 1);
        // Slow memory, reserved kind and a nonzero trailing word
        dly = 3;
        load(64'h0000_0000_0000_0505);
        mdl.mem[39] = 64'h1;
        fetch();
        apb(1'b0, OFS_DESC_STAT, 32'h0);
        `CHK("reserved flag", 1'b1, rd_q[1])
        `CHK("kind", 8'h05, page_kind)
        acc(0, 0, 1, 0);
        acc(0, 1, 0, 1);
        apb(1'b1, OFS_DESC_ADDR, 32'h0000_0048);
        repeat (2) @(posedge clk);
        #1;
        `CHK("no fetch", 1'b0, mem_req)
        apb(1'b0, OFS_DESC_STAT, 32'h0);
        `CHK("align flag", 1'b1, rd_q[0])
    endtask

    // Main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        dly = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        flt_valid = 1'b0;
        flt_vec = 8'h00;
        flt_addr = 64'h0;
        flt_code = 32'h0;
        flt_pk = 1'b0;
        flt_cm = 1'b0;
        acc_rd = 1'b0;
        acc_wr = 1'b0;
        acc_ex = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_area();
        t_faults();
        t_fetch();
        close_out();
    end
endmodule
